/* File: testbench/sbs_host.sv */
/* sbs_host: host side of the shared data wire.
   Assumes the bench sets drive and data with each request. */
`timescale 1ns/100ps
module sbs_host (
    // clock
    input wire logic clk_sys_i,
    // host write side
    input wire logic drive_i,
    input wire sbs_pkg::sbs_data_t wdata_i,
    // device side
    input wire sbs_pkg::sbs_data_t data_o,
    input wire logic data_oe_o,
    output sbs_pkg::sbs_data_t data_i
);
    import sbs_pkg::*;
    sbs_data_t last_ff;
    // undriven wire shows inverse of last value
    assign data_i = data_oe_o ? data_o : drive_i ? wdata_i : ~last_ff;
    always_ff @(posedge clk_sys_i) last_ff <= data_i;
endmodule

/* File: testbench/sbs_properties.sv */
/* sbs_properties: port checks of the burst sram access block.
   Assumes a bind from the bench top; one clock domain. */
`timescale 1ns/100ps
module sbs_properties (
    input wire logic clk_sys_i, reset_i, processor_address_strobe_n_i,
    input wire logic controller_address_strobe_n_i, burst_advance_n_i,
    input wire logic pipelining_chip_select_n_i, expansion_select_high_i,
    input wire logic expansion_select_low_n_i, all_bytes_write_n_i,
    input wire logic byte_write_gate_n_i, output_enable_n_i,
    input wire logic sleep_request_i, data_oe_o,
    input wire sbs_pkg::sbs_data_t data_o
);
    import sbs_pkg::*;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    wire go_p = !processor_address_strobe_n_i & !pipelining_chip_select_n_i;
    wire go_c = !controller_address_strobe_n_i & !go_p;
    wire sel = !pipelining_chip_select_n_i & expansion_select_high_i
        & !expansion_select_low_n_i;
    wire idle = !go_p & controller_address_strobe_n_i & burst_advance_n_i
        & all_bytes_write_n_i & byte_write_gate_n_i;
    sequence desel_s; go_c & !sel; endsequence
    sequence rd_s; go_p & sel; endsequence
    oe_gate_a: assert property (output_enable_n_i |-> !data_oe_o)
        else $error("drive while output enable high");
    sleep_gate_a: assert property (sleep_request_i |-> !data_oe_o)
        else $error("drive while sleeping");
    write_float_a: assert property (go_c & !all_bytes_write_n_i
        |=> !data_oe_o) else $error("drive in write cycle");
    desel_float_a: assert property (desel_s |=> !data_oe_o)
        else $error("drive while deselected");
    first_mask_a: assert property (desel_s ##1 rd_s |=> !data_oe_o)
        else $error("drive in first cycle after deselect");
    select_latch_a: assert property (desel_s ##1 (idle & sel)
        |=> !data_oe_o) else $error("select taken without strobe");
    hold_data_a: assert property (idle ##1 (idle & data_oe_o)
        |=> $stable(data_o)) else $error("data moved while holding");
    proc_wins_a: assert property (rd_s ##1 (rd_s
        & !controller_address_strobe_n_i & !all_bytes_write_n_i)
        |=> data_oe_o | output_enable_n_i | sleep_request_i)
        else $error("controller strobe beat processor strobe");
endmodule

/* File: testbench/sbs_top_bench.sv */
/* sbs_top_bench: scenario tests of the burst sram access block.
   Assumes sbs_host models the host data driver. */
`timescale 1ns/100ps
module sbs_top_bench;
    import sbs_pkg::*;
    logic clk_sys_i = 0, reset_i = 1, burst_order_i = 0, hd = 0;
    logic processor_address_strobe_n_i = 1, controller_address_strobe_n_i = 1;
    logic burst_advance_n_i = 1, pipelining_chip_select_n_i = 0;
    logic expansion_select_high_i = 1, expansion_select_low_n_i = 0;
    logic byte_write_gate_n_i = 1, all_bytes_write_n_i = 1, data_oe_o;
    logic sleep_request_i = 0, output_enable_n_i = 0;
    sbs_lanes_t byte_lane_selects_n_i = 4'hF;
    sbs_addr_t address_i = 18'h0;
    sbs_data_t data_i, data_o, wd = 36'h0;
    sbs_data_t dv [4] = '{36'h5A5A5A5A0, 36'h5A5A5A5A1, 36'h5A5A5A5A2,
        36'h5A5A5A5A3};
    int n_errors = 0, cmp_count = 0;
    localparam sbs_addr_t base = 18'h00104;
    localparam logic [9:0] c_rdp = 10'h1FF, c_wrc = 10'h2BF, c_avw = 10'h33F,
        c_avr = 10'h37F, c_idl = 10'h3FF, c_bwc = 10'h2DE, c_both = 10'h0BF,
        c_dsc = 10'h2AF;
    sbs_top u_dut (.*);
    sbs_host u_host (.clk_sys_i, .drive_i(hd), .wdata_i(wd), .data_o,
        .data_oe_o, .data_i);
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    task automatic give_verdict;
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [36:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // request c at this edge, check result of the previous edge
    task automatic cyc(input logic [9:0] c, input sbs_addr_t a,
        input sbs_data_t d, input logic [1:0] k, input sbs_data_t e);
        logic w;
        w = c[9] & !(c[6] & c[5]);
        @(posedge clk_sys_i);
        {processor_address_strobe_n_i, controller_address_strobe_n_i,
            burst_advance_n_i, all_bytes_write_n_i, byte_write_gate_n_i,
            expansion_select_high_i, byte_lane_selects_n_i} <= c;
        address_i <= a;
        wd <= d;
        hd <= w;
        output_enable_n_i <= w & !c[8];
        #1;
        if (k[1]) chk({data_oe_o, k[0] ? data_o : e}, {k[0], e});
    endtask
    task automatic s_burst;
        cyc(c_wrc, base, dv[0], 2'b00, '0);
        for (int i = 1; i < 4; i++) cyc(c_avw, base, dv[i], 2'b10, '0);
        cyc(c_rdp, base | 18'h1, '0, 2'b10, '0);
        for (int i = 1; i < 5; i++) cyc(c_avr, base, '0, 2'b11, dv[i % 4]);
        @(posedge clk_sys_i) burst_order_i <= 1'b1;
        repeat (2) cyc(c_dsc, base, '0, 2'b00, '0);
        repeat (2) cyc(c_rdp, base | 18'h1, '0, 2'b00, '0);
        for (int i = 0; i < 4; i++) cyc(c_avr, base, '0, 2'b11, dv[i ^ 1]);
    endtask
    task automatic s_lanes;
        sbs_data_t lv;
        lv = {dv[0][35:9], 9'h1FF};
        cyc(c_bwc, base, 36'hFFFFFFFFF, 2'b00, '0);
        cyc(c_rdp, base, '0, 2'b10, '0);
        cyc(c_both, base, '0, 2'b11, lv);
        repeat (3) cyc(c_idl, base, '0, 2'b11, lv);
        @(posedge clk_sys_i) sleep_request_i <= 1'b1;
        #1 chk({data_oe_o, 36'h0}, 37'h0);
        @(posedge clk_sys_i) sleep_request_i <= 1'b0;
    endtask
    task automatic s_desel;
        cyc(c_dsc, base | 18'h2, '0, 2'b00, '0);
        cyc(c_idl, base, '0, 2'b10, '0);
        cyc(c_dsc, base | 18'h2, '0, 2'b10, '0);
        cyc(c_rdp, base | 18'h2, '0, 2'b10, '0);
        cyc(c_rdp, base | 18'h2, '0, 2'b10, '0);
        cyc(c_idl, base, '0, 2'b11, dv[2]);
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        s_burst;
        s_lanes;
        s_desel;
        give_verdict;
    end
    initial begin
        #5000;
        n_errors++;
        give_verdict;
    end
endmodule
bind sbs_top sbs_properties u_chk (.*);

/* File: verilog/sbs_map.svh */
/*
 * sbs_map.svh: widths and fixed values of the burst sram access block.
 * Assumes it is included by bare name before any user of these macros.
 */
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

`define SBS_ADDR_W 18
`define SBS_DEPTH 262144
`define SBS_DATA_W 36
`define SBS_LANES 4
`define SBS_LANE_W 9
`define SBS_CNT_W 2
`define SBS_CNT_ZERO 2'h0
`define SBS_CNT_STEP 2'h1
`define SBS_LANES_ALL 4'hF
`define SBS_LANES_NONE 4'h0
`define SBS_DATA_ZERO 36'h0
`define SBS_ADDR_ZERO 18'h0

`endif

/* File: verilog/sbs_pkg.sv */
/*
 * sbs_pkg: types of the burst sram access block.
 * Assumes sbs_map.svh is reachable on the include path.
 */
`include "sbs_map.svh"

package sbs_pkg;

    typedef logic [`SBS_ADDR_W-1:0] sbs_addr_t;
    typedef logic [`SBS_DATA_W-1:0] sbs_data_t;
    typedef logic [`SBS_LANES-1:0] sbs_lanes_t;
    typedef logic [`SBS_CNT_W-1:0] sbs_cnt_t;

    typedef struct packed {
        logic order_meta;
        logic order_sync;
        sbs_addr_t base_addr;
        sbs_cnt_t count;
        logic sel;
        logic rd;
        logic fresh;
        sbs_data_t dout;
    } sbs_state_t;

endpackage

/* File: verilog/sbs_top.sv */
/*
 * sbs_top: access logic of a synchronous flow-through burst sram,
 * 256K words of 36 bits with four 9-bit byte lanes and common data lines.
 * Assumes the host drives all synchronous inputs from logic on clk_sys_i;
 * the data wire is resolved outside from data_o and data_oe_o.
 */
`timescale 1ns/100ps

module sbs_top (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // address and burst control
    input wire sbs_pkg::sbs_addr_t address_i,
    input wire logic processor_address_strobe_n_i,
    input wire logic controller_address_strobe_n_i,
    input wire logic burst_advance_n_i,
    input wire logic burst_order_i,
    // chip selects
    input wire logic pipelining_chip_select_n_i,
    input wire logic expansion_select_high_i,
    input wire logic expansion_select_low_n_i,
    // write controls
    input wire logic byte_write_gate_n_i,
    input wire sbs_pkg::sbs_lanes_t byte_lane_selects_n_i,
    input wire logic all_bytes_write_n_i,
    // asynchronous controls
    input wire logic output_enable_n_i,
    input wire logic sleep_request_i,
    // data lines
    input wire sbs_pkg::sbs_data_t data_i,
    output sbs_pkg::sbs_data_t data_o,
    output logic data_oe_o
);
    import sbs_pkg::*;

    sbs_state_t state_ff;
    sbs_state_t nxt_state;

    // read word gathered from the lanes
    wire sbs_data_t rd_word;

    // strobe and select decode
    logic proc_start;
    logic ctrl_start;
    logic load;
    logic new_sel;
    logic cur_sel;
    logic cur_order;
    sbs_addr_t cur_base;
    sbs_cnt_t cur_count;
    // burst address path
    sbs_cnt_t offset;
    sbs_cnt_t offset_ilv;
    sbs_cnt_t offset_lin;
    sbs_addr_t access_addr;

    // write lanes
    sbs_lanes_t wr_lanes;
    logic wr_block;
    logic wr_any;

    // output drive terms
    logic read_ready;
    logic pins_free;

    // strobe arbitration
    always_comb begin
        proc_start = !processor_address_strobe_n_i &&
            !pipelining_chip_select_n_i;
        ctrl_start = !controller_address_strobe_n_i && !proc_start;
        load = proc_start || ctrl_start;
    end

    // selection seen by a new address
    always_comb begin
        new_sel = !pipelining_chip_select_n_i && expansion_select_high_i &&
            !expansion_select_low_n_i;
    end

    // address and counter selection
    always_comb begin
        cur_order = state_ff.order_sync;
        // new burst start
        if (load) begin
            cur_base = address_i;
            cur_count = `SBS_CNT_ZERO;
            cur_sel = new_sel;
        end else if (!burst_advance_n_i) begin
            // step the burst
            cur_base = state_ff.base_addr;
            cur_count = sbs_cnt_t'(state_ff.count + `SBS_CNT_STEP);
            cur_sel = state_ff.sel;
        end else begin
            cur_base = state_ff.base_addr;
            cur_count = state_ff.count;
            cur_sel = state_ff.sel;
        end
        // both orders, strap picks one
        offset_ilv = cur_base[`SBS_CNT_W-1:0] ^ cur_count;
        offset_lin = sbs_cnt_t'(cur_base[`SBS_CNT_W-1:0] + cur_count);
        if (cur_order) begin
            offset = offset_ilv;
        end else begin
            offset = offset_lin;
        end
        access_addr = {cur_base[`SBS_ADDR_W-1:`SBS_CNT_W], offset};
    end

    // write lane decode
    always_comb begin
        if (!all_bytes_write_n_i) begin
            wr_lanes = `SBS_LANES_ALL;
        end else if (!byte_write_gate_n_i) begin
            wr_lanes = ~byte_lane_selects_n_i;
        end else begin
            wr_lanes = `SBS_LANES_NONE;
        end
        // processor strobe cycle never writes; writes follow it
        wr_block = proc_start || !cur_sel || sleep_request_i;
        if (wr_block) begin
            wr_lanes = `SBS_LANES_NONE;
        end
        wr_any = |wr_lanes;
    end

    // next state
    always_comb begin
        nxt_state = state_ff;
        // order strap through two flops
        nxt_state.order_meta = burst_order_i;
        nxt_state.order_sync = state_ff.order_meta;
        nxt_state.base_addr = cur_base;
        nxt_state.count = cur_count;
        nxt_state.sel = cur_sel;
        nxt_state.rd = cur_sel && !wr_any;
        nxt_state.fresh = load && new_sel && !state_ff.sel;
        if (cur_sel && !wr_any) begin
            nxt_state.dout = rd_word;
        end
        // reset values, memory untouched
        if (reset_i) begin
            nxt_state.order_meta = 1'b0;
            nxt_state.order_sync = 1'b0;
            nxt_state.base_addr = `SBS_ADDR_ZERO;
            nxt_state.count = `SBS_CNT_ZERO;
            nxt_state.sel = 1'b0;
            nxt_state.rd = 1'b0;
            nxt_state.fresh = 1'b0;
            nxt_state.dout = `SBS_DATA_ZERO;
        end
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        state_ff <= nxt_state;
    end

    // byte lanes: own storage, write and read path per lane
    genvar lane;
    generate
        for (lane = 0; lane < `SBS_LANES; lane = lane + 1) begin : g_lane
            // one lane of every word
            logic [`SBS_LANE_W-1:0] lane_mem [0:`SBS_DEPTH-1];
            logic lane_we;
            logic [`SBS_LANE_W-1:0] lane_wdata;
            logic [`SBS_LANE_W-1:0] lane_rdata;

            // write only outside reset
            always_comb begin
                lane_we = wr_lanes[lane] && !reset_i;
                lane_wdata = data_i[lane*`SBS_LANE_W +: `SBS_LANE_W];
            end

            // lane write on the command edge
            always_ff @(posedge clk_sys_i) begin
                if (lane_we) begin
                    lane_mem[access_addr] <= lane_wdata;
                end
            end

            // flow-through read of the addressed word
            always_comb begin
                lane_rdata = lane_mem[access_addr];
            end

            // lane slice of the read word
            assign rd_word[lane*`SBS_LANE_W +: `SBS_LANE_W] = lane_rdata;
        end
    endgenerate

    // data drive, gated by unregistered controls
    assign data_o = state_ff.dout;

    // settled read of a selected word
    always_comb begin
        read_ready = state_ff.sel && state_ff.rd && !state_ff.fresh;
        pins_free = !output_enable_n_i && !sleep_request_i;
    end

    assign data_oe_o = read_ready && pins_free;

endmodule
